// ---- usps_far_side_model.sv ----
// far-side model: host frame traffic, regulator and pll settling
`timescale 1ns/1ps
`default_nettype none
module usps_far_side_model (
    input wire logic core_clk, // core clock
    input wire logic rst, // async reset, active high
    input wire logic hostIdle, // host stops frames and idles the bus
    input wire logic regulatorEnable, // regulator powered by the device
    input wire logic oscEnable, // oscillator enabled by the device
    output logic sofSeen, // start-of-frame pulse
    output logic busIdle, // bus idle level
    output logic regReady, // regulator output stable
    output logic pllLocked // pll settled
);
    logic [2:0] sofCnt;
    logic [2:0] regSh;
    logic [2:0] pllSh;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sofCnt <= 3'h0;
            busIdle <= 1'h0;
            sofSeen <= 1'h0;
            regSh <= 3'h0;
            pllSh <= 3'h0;
        end else begin
            sofCnt <= sofCnt + 3'h1;
            busIdle <= hostIdle;
            sofSeen <= !hostIdle && (sofCnt == 3'h7);
            regSh <= {regSh[1:0], regulatorEnable};
            pllSh <= {pllSh[1:0], oscEnable};
        end
    end

    // stability is lost at once when power or oscillator drops
    assign regReady = regulatorEnable && regSh[2];
    assign pllLocked = oscEnable && pllSh[2];
endmodule : usps_far_side_model
`default_nettype wire

// ---- usps_pkg.sv ----
// constants for the suspend, wake-up and power-state sequencer
package usps_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int US_PER_MS = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000;
    localparam int TICK_W = 6;
    localparam int TMR_W = 14;
    localparam int POR_W = 8;

    // times as printed, in milliseconds
    localparam int IDLE_SUSPEND_MS = 3;
    localparam int SUSPEND_FLAG_MIN_MS = 5;
    localparam int RESUME_MS = 5;
    localparam int RWK_DELAY_MS = 5;
    localparam int RWK_DRIVE_MS = 10;

    // the same times as counts of microsecond ticks
    localparam int IDLE_SUSPEND_US = IDLE_SUSPEND_MS * US_PER_MS;
    localparam int SUSPEND_FLAG_MIN_US = SUSPEND_FLAG_MIN_MS * US_PER_MS;
    localparam int RESUME_US = RESUME_MS * US_PER_MS;
    localparam int RWK_DELAY_US = RWK_DELAY_MS * US_PER_MS;
    localparam int RWK_DRIVE_US = RWK_DRIVE_MS * US_PER_MS;

    // clock cycles that the internal reset stays on once the regulator is stable
    localparam int POR_HOLD_CYC = 16;

    // reference clock codes on the two frequency-select pins
    localparam logic [1:0] REF_12M = 2'h0;
    localparam logic [1:0] REF_19M2 = 2'h1;
    localparam logic [1:0] REF_24M = 2'h2;
    localparam logic [1:0] REF_BAD = 2'h3;

    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_POWERUP = 6'h02,
        ST_RUN = 6'h04,
        ST_SUSPEND_FLAG = 6'h08,
        ST_WAKE = 6'h10,
        ST_DEEP = 6'h20
    } usps_state_t;

    typedef enum logic [2:0] {
        RW_IDLE = 3'h1,
        RW_WAIT = 3'h2,
        RW_DRIVE = 3'h4
    } usps_rwk_t;

    typedef struct packed {
        usps_state_t st;
        usps_rwk_t rwkPh;
        logic [TICK_W-1:0] tickCnt;
        logic [TMR_W-1:0] idleCnt;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] rwkCnt;
        logic [POR_W-1:0] porCnt;
        logic idleDone;
        logic suspFlag;
        logic resmFlag;
        logic gosPrev;
        logic rsuPrev;
        logic pwrPrev;
        logic writeLock;
        logic driveK;
        logic busPres;
        logic [1:0] refCode;
    } usps_regs_t;
endpackage : usps_pkg

// ---- usps_power_seq.sv ----
// suspend, resume, remote wake-up and regulator power sequencer
`timescale 1ns/1ps
`default_nettype none

module usps_power_seq
    import usps_pkg::*;
#(
    parameter logic [TMR_W-1:0] IDLE_US = TMR_W'(IDLE_SUSPEND_US),
    parameter logic [TMR_W-1:0] SUSPEND_FLAG_US = TMR_W'(SUSPEND_FLAG_MIN_US),
    parameter logic [TMR_W-1:0] RESM_US = TMR_W'(RESUME_US),
    parameter logic [TMR_W-1:0] RWKD_US = TMR_W'(RWK_DELAY_US),
    parameter logic [TMR_W-1:0] RWKK_US = TMR_W'(RWK_DRIVE_US),
    parameter logic [TICK_W-1:0] TICK_N = TICK_W'(TICK_CYC),
    parameter logic [POR_W-1:0] POR_N = POR_W'(POR_HOLD_CYC)
) (
    input wire logic core_clk, // 40 MHz core clock
    input wire logic rst, // async reset, active high
    input wire logic extResetN, // external reset pin, active low
    input wire logic sofSeen, // start-of-frame received, pulse
    input wire logic busIdle, // bus in idle (J) state
    input wire logic busK, // host drives K-state (global resume)
    input wire logic busPresenceIn, // bus supply present
    input wire logic csN, // chip select pin, active low
    input wire logic read_strobe_n, // read strobe pin, active low
    input wire logic wake_on_select, // allow select-pulse wake from suspend
    input wire logic suspend_irq_enable, // suspend interrupt enable
    input wire logic resume_irq_enable, // resume interrupt enable
    input wire logic clocks_always_on, // keep clocks running in suspend
    input wire logic enter_suspend_strobe, // enter-suspend control bit
    input wire logic send_resume_strobe, // remote wake-up control bit
    input wire logic unlockCmd, // unlock command, pulse
    input wire logic clrSuspendFlag, // clear suspend flag, pulse
    input wire logic clrResumeFlag, // clear resume flag, pulse
    input wire logic regulator_power_on, // regulator power bit
    input wire logic regulator_suspend, // regulator suspend bit
    input wire logic remoteWakeDev, // remote wake from attached device
    input wire logic overcurrent, // bus supply overcurrent
    input wire logic regReady, // regulator output stable
    input wire logic pllLocked, // oscillator and PLL settled
    input wire logic pll_freq_sel_a, // reference select pin a
    input wire logic pll_freq_sel_b, // reference select pin b
    output logic suspend_flag, // suspend status flag
    output logic resumeFlag, // resume status flag
    output logic periphIrq, // peripheral interrupt request
    output logic bus_presence_status, // registered bus presence
    output logic suspended, // peripheral in suspend state
    output logic oscEnable, // oscillator and PLL enable
    output logic periphClkEnable, // peripheral clock gate
    output logic hostClkEnable, // host clock gate
    output logic regulatorEnable, // regulator powered
    output logic regulatorSuspended, // regulator in suspend
    output logic porActive, // internal power-on reset
    output logic driveK, // drive K-state on the bus
    output logic writeLock, // register writes blocked
    output logic [1:0] pllRefCode, // decoded reference frequency
    output logic pllRefValid // reference select legal
);

    function automatic logic [1:0] ref_decode(input logic a, input logic b);
        case ({b, a})
            2'h0: ref_decode = REF_12M;
            2'h1: ref_decode = REF_19M2;
            2'h2: ref_decode = REF_24M;
            default: ref_decode = REF_BAD;
        endcase
    endfunction : ref_decode

    usps_regs_t r_reg;
    usps_regs_t r_next;
    logic usTick;
    logic gosFall;
    logic rsuFall;
    logic pwrFall;
    logic selWake;
    logic suspWake;
    logic devWake;
    logic suspSet;
    logic resmSet;
    logic suspOpen;

    always_comb begin
        r_next = r_reg;
        usTick = (r_reg.tickCnt == TICK_N - TICK_W'(1));
        r_next.tickCnt = usTick ? '0 : r_reg.tickCnt + TICK_W'(1);
        gosFall = r_reg.gosPrev & ~enter_suspend_strobe;
        rsuFall = r_reg.rsuPrev & ~send_resume_strobe;
        pwrFall = r_reg.pwrPrev & ~regulator_power_on;
        selWake = ~csN & ~read_strobe_n;
        suspOpen = (r_reg.tmr >= SUSPEND_FLAG_US);
        suspWake = busK | (selWake & wake_on_select);
        devWake = selWake | remoteWakeDev | overcurrent | busK;
        suspSet = 1'b0;
        resmSet = 1'b0;
        r_next.gosPrev = enter_suspend_strobe;
        r_next.rsuPrev = send_resume_strobe;
        r_next.pwrPrev = regulator_power_on;
        r_next.busPres = busPresenceIn;
        r_next.refCode = ref_decode(pll_freq_sel_a, pll_freq_sel_b);
        if (unlockCmd) begin
            r_next.writeLock = 1'b0;
        end
        // idle watch: one flag per continuous idle stretch
        if (r_reg.st == ST_RUN && busIdle && !sofSeen) begin
            if (!r_reg.idleDone && usTick) begin
                if (r_reg.idleCnt == IDLE_US - TMR_W'(1)) begin
                    r_next.idleDone = 1'b1;
                    r_next.idleCnt = '0;
                    suspSet = 1'b1;
                end else begin
                    r_next.idleCnt = r_reg.idleCnt + TMR_W'(1);
                end
            end
        end else begin
            r_next.idleCnt = '0;
            r_next.idleDone = 1'b0;
        end
        case (r_reg.st)
            ST_OFF: begin
                if (devWake) begin
                    r_next.st = ST_POWERUP;
                    r_next.porCnt = '0;
                end
            end
            ST_POWERUP: begin
                if (!regReady) begin
                    r_next.porCnt = '0;
                end else if (r_reg.porCnt == POR_N - POR_W'(1)) begin
                    r_next.st = ST_RUN;
                end else begin
                    r_next.porCnt = r_reg.porCnt + POR_W'(1);
                end
            end
            ST_RUN: begin
                if (gosFall) begin
                    r_next.st = ST_SUSPEND_FLAG;
                    r_next.tmr = '0;
                end else if (regulator_power_on && regulator_suspend) begin
                    r_next.st = ST_DEEP;
                end
            end
            ST_SUSPEND_FLAG: begin
                if (!suspOpen) begin
                    if (usTick) begin
                        r_next.tmr = r_reg.tmr + TMR_W'(1);
                    end
                end else if (suspWake || rsuFall) begin
                    r_next.st = ST_WAKE;
                    r_next.tmr = '0;
                    resmSet = 1'b1;
                end else if (regulator_power_on && regulator_suspend) begin
                    r_next.st = ST_DEEP;
                end
            end
            ST_DEEP: begin
                if (devWake) begin
                    r_next.st = ST_WAKE;
                    r_next.tmr = '0;
                    resmSet = 1'b1;
                end
            end
            ST_WAKE: begin
                if (usTick) begin
                    if (r_reg.tmr == RESM_US - TMR_W'(1)) begin
                        r_next.st = ST_RUN;
                        r_next.writeLock = 1'b1;
                    end else begin
                        r_next.tmr = r_reg.tmr + TMR_W'(1);
                    end
                end
            end
            default: begin
                r_next.st = ST_OFF;
            end
        endcase
        // remote wake-up: delay, then K-state
        case (r_reg.rwkPh)
            RW_IDLE: begin
                if (rsuFall && (r_reg.st == ST_RUN || (r_reg.st == ST_SUSPEND_FLAG && suspOpen))) begin
                    r_next.rwkPh = RW_WAIT;
                    r_next.rwkCnt = '0;
                end
            end
            RW_WAIT: begin
                if (usTick) begin
                    if (r_reg.rwkCnt == RWKD_US - TMR_W'(1)) begin
                        r_next.rwkPh = RW_DRIVE;
                        r_next.rwkCnt = '0;
                    end else begin
                        r_next.rwkCnt = r_reg.rwkCnt + TMR_W'(1);
                    end
                end
            end
            RW_DRIVE: begin
                if (usTick) begin
                    if (r_reg.rwkCnt == RWKK_US - TMR_W'(1)) begin
                        r_next.rwkPh = RW_IDLE;
                    end else begin
                        r_next.rwkCnt = r_reg.rwkCnt + TMR_W'(1);
                    end
                end
            end
            default: begin
                r_next.rwkPh = RW_IDLE;
            end
        endcase
        if (!extResetN || pwrFall) begin
            r_next.st = ST_OFF;
            r_next.rwkPh = RW_IDLE;
            r_next.writeLock = 1'b0;
        end
        r_next.driveK = (r_next.rwkPh == RW_DRIVE);
        // a set in the same cycle as a clear wins
        r_next.suspFlag = suspSet | (r_reg.suspFlag & ~clrSuspendFlag);
        r_next.resmFlag = resmSet | (r_reg.resmFlag & ~clrResumeFlag);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r_reg <= '{st: ST_OFF, rwkPh: RW_IDLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign suspend_flag = r_reg.suspFlag;
    assign resumeFlag = r_reg.resmFlag;
    assign periphIrq = (r_reg.suspFlag & suspend_irq_enable) |
                       (r_reg.resmFlag & resume_irq_enable);
    assign bus_presence_status = r_reg.busPres;
    assign suspended = (r_reg.st == ST_SUSPEND_FLAG);
    assign oscEnable = (r_reg.st == ST_RUN) || (r_reg.st == ST_WAKE) ||
                       (r_reg.st == ST_POWERUP) || (suspended && clocks_always_on);
    assign periphClkEnable = oscEnable && pllLocked && (r_reg.st != ST_POWERUP);
    assign hostClkEnable = pllLocked && ((r_reg.st == ST_RUN) || (r_reg.st == ST_WAKE) ||
                                         suspended);
    assign regulatorEnable = (r_reg.st != ST_OFF);
    assign regulatorSuspended = (r_reg.st == ST_DEEP);
    assign porActive = (r_reg.st == ST_OFF) || (r_reg.st == ST_POWERUP);
    assign driveK = r_reg.driveK;
    assign writeLock = r_reg.writeLock;
    assign pllRefCode = r_reg.refCode;
    assign pllRefValid = (r_reg.refCode != REF_BAD);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_idle_flag_set: assert property ($rose(suspend_flag) |->
        $past(r_reg.idleCnt) == IDLE_US - TMR_W'(1) && $past(busIdle))
        else $error("suspend flag rose without a full idle stretch");
    chk_idle_restart: assert property (sofSeen |=> r_reg.idleCnt == '0)
        else $error("start-of-frame did not restart the idle count");
    chk_suspend_flag_irq_gate: assert property (r_reg.suspFlag && !r_reg.resmFlag &&
        !suspend_irq_enable |-> !periphIrq)
        else $error("suspend interrupt raised while disabled");
    chk_enter_suspend_flag: assert property (r_reg.st == ST_RUN && gosFall && extResetN &&
        !pwrFall |=> suspended)
        else $error("set-then-clear did not enter suspend");
    chk_suspend_flag_min_hold: assert property ($rose(suspended) |-> suspended [*8])
        else $error("suspend left too early");
    chk_wake_after_min: assert property (suspended && r_next.st == ST_WAKE |->
        r_reg.tmr >= SUSPEND_FLAG_US)
        else $error("wake accepted before minimum suspend time");
    chk_sel_wake_gate: assert property (suspended && suspOpen && !busK && !rsuFall &&
        !wake_on_select && extResetN && !pwrFall && !regulator_suspend |=> suspended)
        else $error("select pulse woke device while disabled");
    chk_host_k_wake: assert property (suspended && suspOpen && busK && extResetN &&
        !pwrFall |=> r_reg.st == ST_WAKE)
        else $error("host resume ignored after minimum suspend time");
    chk_clk_after_lock: assert property (periphClkEnable |-> pllLocked && oscEnable)
        else $error("peripheral clock before PLL settled");
    chk_wake_osc_on: assert property ($rose(resumeFlag) && !porActive |->
        oscEnable)
        else $error("oscillator not enabled on wake");
    chk_resume_flag: assert property (r_reg.st == ST_SUSPEND_FLAG && r_next.st == ST_WAKE |=>
        resumeFlag)
        else $error("resume flag not set on wake");
    chk_res_irq_gate: assert property (r_reg.resmFlag && !r_reg.suspFlag &&
        !resume_irq_enable |-> !periphIrq)
        else $error("resume interrupt raised while disabled");
    chk_wake_to_run: assert property (r_reg.st == ST_WAKE && r_next.st == ST_RUN |->
        r_reg.tmr == RESM_US - TMR_W'(1) && usTick)
        else $error("normal operation not at end of resume time");
    chk_lock_on_run: assert property ($past(r_reg.st) == ST_WAKE &&
        r_reg.st == ST_RUN |-> writeLock)
        else $error("writes not locked after resume");
    chk_k_after_wait: assert property ($rose(driveK) |->
        $past(r_reg.rwkPh) == RW_WAIT && $past(r_reg.rwkCnt) == RWKD_US - TMR_W'(1))
        else $error("K-state started without full delay");
    chk_k_drive_len: assert property ($fell(driveK) |->
        $past(r_reg.rwkCnt) == RWKK_US - TMR_W'(1) || $past(!extResetN || pwrFall))
        else $error("K-state ended before its full length");
    chk_ref_bad: assert property (pll_freq_sel_a && pll_freq_sel_b |=> !pllRefValid)
        else $error("illegal reference select reported valid");
    chk_deep_entry: assert property (r_reg.st == ST_RUN && !gosFall && extResetN &&
        regulator_power_on && regulator_suspend |=> regulatorSuspended)
        else $error("regulator bits did not enter deep sleep");
    chk_deep_clocks: assert property (regulatorSuspended |-> !periphClkEnable &&
        !hostClkEnable && regulatorEnable)
        else $error("clocks running in deep sleep");
    chk_pwr_bit_off: assert property (pwrFall |=> !regulatorEnable && porActive)
        else $error("regulator still on after power bit cleared");
    chk_dummy_read: assert property (r_reg.st == ST_OFF && selWake && extResetN &&
        !pwrFall |=> regulatorEnable && porActive)
        else $error("dummy read did not power the regulator");
    chk_deep_wake: assert property (regulatorSuspended && devWake && extResetN &&
        !pwrFall |=> r_reg.st == ST_WAKE)
        else $error("wake source did not leave deep sleep");
    chk_pwr_down: assert property (!extResetN |=> !regulatorEnable && porActive)
        else $error("regulator still on after reset pin");
    chk_por_hold: assert property (r_reg.st == ST_POWERUP && !regReady |=> porActive)
        else $error("internal reset released before regulator stable");

    cov_suspend_resume: cover property (suspended ##1 r_reg.st == ST_WAKE);
    cov_remote_wake: cover property ($rose(driveK));
    cov_deep_wake: cover property (regulatorSuspended ##1 r_reg.st == ST_WAKE);
    cov_power_up: cover property (r_reg.st == ST_POWERUP ##1 r_reg.st == ST_RUN);
    cov_select_wake: cover property (suspended && selWake && wake_on_select ##1 r_reg.st == ST_WAKE);

endmodule : usps_power_seq

`default_nettype wire

// ---- usps_power_seq_tb.sv ----
// self-checking bench for the power-state sequencer
`timescale 1ns/1ps
`default_nettype none
module usps_power_seq_tb;
    import usps_pkg::*;
    localparam int TN = 2;
    localparam int IDL = 10;
    localparam int SUS = 6;
    localparam int RSM = 5;
    localparam int RKD = 4;
    localparam int RKK = 8;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic extResetN = 1'h1, busPresenceIn = 1'h1, csN = 1'h1, read_strobe_n = 1'h1;
    logic regulator_power_on = 1'h1, clocks_always_on = 1'h1, busK = 1'h0, hostIdle = 1'h0;
    logic wake_on_select = 1'h0, suspend_irq_enable = 1'h0, resume_irq_enable = 1'h0;
    logic enter_suspend_strobe = 1'h0, send_resume_strobe = 1'h0, unlockCmd = 1'h0;
    logic clrSuspendFlag = 1'h0, clrResumeFlag = 1'h0, regulator_suspend = 1'h0;
    logic remoteWakeDev = 1'h0, overcurrent = 1'h0, pll_freq_sel_a = 1'h0, pll_freq_sel_b = 1'h0;
    wire logic sofSeen, busIdle, regReady, pllLocked, suspend_flag, resumeFlag, periphIrq;
    wire logic bus_presence_status, suspended, oscEnable, periphClkEnable, hostClkEnable;
    wire logic regulatorEnable, regulatorSuspended, porActive, driveK, writeLock, pllRefValid;
    wire logic [1:0] pllRefCode;
    int n_errors = 0;
    int n_compared = 0;

    usps_power_seq #(.IDLE_US(TMR_W'(IDL)), .SUSPEND_FLAG_US(TMR_W'(SUS)), .RESM_US(TMR_W'(RSM)),
        .RWKD_US(TMR_W'(RKD)), .RWKK_US(TMR_W'(RKK)), .TICK_N(TICK_W'(TN)),
        .POR_N(POR_W'(2))) usps_power_seq_inst (
        .core_clk, .rst, .extResetN, .sofSeen, .busIdle, .busK, .busPresenceIn, .csN,
        .read_strobe_n, .wake_on_select, .suspend_irq_enable, .resume_irq_enable,
        .clocks_always_on, .enter_suspend_strobe, .send_resume_strobe, .unlockCmd,
        .clrSuspendFlag, .clrResumeFlag, .regulator_power_on, .regulator_suspend,
        .remoteWakeDev, .overcurrent, .regReady, .pllLocked, .pll_freq_sel_a,
        .pll_freq_sel_b, .suspend_flag, .resumeFlag, .periphIrq, .bus_presence_status,
        .suspended, .oscEnable, .periphClkEnable, .hostClkEnable, .regulatorEnable,
        .regulatorSuspended, .porActive, .driveK, .writeLock, .pllRefCode, .pllRefValid);

    usps_far_side_model usps_far_side_model_inst (.core_clk, .rst, .hostIdle,
        .regulatorEnable, .oscEnable, .sofSeen, .busIdle, .regReady, .pllLocked);

    always #12.5 core_clk = ~core_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : cyc

    task automatic chk_val(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_win(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_win

    function automatic logic pick(input int sel);
        case (sel)
            0: return porActive;
            1: return suspend_flag;
            2: return resumeFlag;
            3: return writeLock;
            default: return driveK;
        endcase
    endfunction : pick

    // bounded wait, the count shows up in the caller's window check
    task automatic wait_for(input int sel, input logic v, output int n);
        n = 0;
        while (pick(sel) !== v && n < 400) begin
            cyc(1);
            n++;
        end
        if (pick(sel) !== v) begin
            n_errors++;
            $display("[ERR] wait%0d expected %h seen %h", sel, v, pick(sel));
        end
    endtask : wait_for

    task automatic enter_suspend_flag;
        clocks_always_on = 1'h0;
        cyc(1);
        chk_val("busPresence", 4'h1, bus_presence_status);
        enter_suspend_strobe = 1'h1;
        cyc(1);
        enter_suspend_strobe = 1'h0;
        cyc(2);
        chk_val("suspended", 4'h1, suspended);
    endtask : enter_suspend_flag

    task automatic finish_wake(output int n);
        hostIdle = 1'h0;
        wait_for(3, 1'h1, n);
        chk_val("locked", 4'h1, writeLock);
        chk_val("suspendedOff", 4'h0, suspended);
        unlockCmd = 1'h1;
        cyc(1);
        unlockCmd = 1'h0;
        cyc(1);
        chk_val("unlocked", 4'h0, writeLock);
        clrResumeFlag = 1'h1;
        cyc(1);
        clrResumeFlag = 1'h0;
    endtask : finish_wake

    task automatic t_powerup;
        int n;
        chk_val("regOff", 4'h0, regulatorEnable);
        csN = 1'h0;
        read_strobe_n = 1'h0;
        cyc(1);
        csN = 1'h1;
        read_strobe_n = 1'h1;
        wait_for(0, 1'h0, n);
        chk_win("porTime", 3, 20, n);
        chk_val("regOn", 4'h1, regulatorEnable);
        $display("test powerup done");
    endtask : t_powerup

    task automatic t_idle;
        int n;
        cyc(40);
        chk_val("noIdleFlag", 4'h0, suspend_flag);
        busPresenceIn = 1'h0;
        cyc(2);
        chk_val("busGone", 4'h0, bus_presence_status);
        busPresenceIn = 1'h1;
        hostIdle = 1'h1;
        wait_for(1, 1'h1, n);
        chk_win("idleTime", IDL * TN - TN, IDL * TN + TN + 4, n);
        chk_val("irqMasked", 4'h0, periphIrq);
        suspend_irq_enable = 1'h1;
        cyc(1);
        chk_val("irqOn", 4'h1, periphIrq);
        suspend_irq_enable = 1'h0;
        clrSuspendFlag = 1'h1;
        cyc(1);
        clrSuspendFlag = 1'h0;
        cyc(1);
        chk_val("flagClr", 4'h0, suspend_flag);
        $display("test idle done");
    endtask : t_idle

    task automatic t_suspend;
        int n;
        enter_suspend_flag();
        cyc(3);
        busK = 1'h1;
        cyc(2);
        busK = 1'h0;
        cyc(1);
        chk_val("earlyWake", 4'h1, suspended);
        chk_val("earlyResume", 4'h0, resumeFlag);
        cyc(SUS * TN + 4);
        busK = 1'h1;
        wait_for(2, 1'h1, n);
        chk_win("hostWake", 0, 2, n);
        chk_val("oscOn", 4'h1, oscEnable);
        chk_val("clkGated", 4'h0, periphClkEnable);
        chk_val("resIrqOff", 4'h0, periphIrq);
        busK = 1'h0;
        resume_irq_enable = 1'h1;
        cyc(5);
        chk_val("clkOn", 4'h1, periphClkEnable);
        chk_val("resIrqOn", 4'h1, periphIrq);
        resume_irq_enable = 1'h0;
        finish_wake(n);
        chk_win("resumeTime", RSM * TN - TN, RSM * TN + TN + 3, n + 5);
        $display("test suspend done");
    endtask : t_suspend

    task automatic t_select;
        int n;
        enter_suspend_flag();
        cyc(SUS * TN + 4);
        csN = 1'h0;
        read_strobe_n = 1'h0;
        cyc(2);
        csN = 1'h1;
        read_strobe_n = 1'h1;
        cyc(2);
        chk_val("selIgnored", 4'h1, suspended);
        wake_on_select = 1'h1;
        csN = 1'h0;
        read_strobe_n = 1'h0;
        wait_for(2, 1'h1, n);
        csN = 1'h1;
        read_strobe_n = 1'h1;
        chk_win("selWake", 0, 2, n);
        finish_wake(n);
        $display("test select done");
    endtask : t_select

    task automatic t_remote;
        int n;
        send_resume_strobe = 1'h1;
        cyc(1);
        send_resume_strobe = 1'h0;
        wait_for(4, 1'h1, n);
        chk_win("rwkDelay", RKD * TN - TN, RKD * TN + TN + 3, n);
        wait_for(4, 1'h0, n);
        chk_win("rwkDrive", RKK * TN - TN, RKK * TN + TN + 1, n);
        for (int i = 0; i < 4; i++) begin
            {pll_freq_sel_b, pll_freq_sel_a} = 2'(i);
            cyc(2);
            chk_val("refCode", 4'(i), pllRefCode);
            chk_val("refValid", 4'(i != 3), pllRefValid);
        end
        $display("test remote done");
    endtask : t_remote

    task automatic t_power;
        int n;
        enter_suspend_flag();
        cyc(SUS * TN + 4);
        regulator_suspend = 1'h1;
        cyc(2);
        chk_val("deep", 4'h1, regulatorSuspended);
        chk_val("hostClkOff", 4'h0, hostClkEnable);
        chk_val("perClkOff", 4'h0, periphClkEnable);
        regulator_suspend = 1'h0;
        overcurrent = 1'h1;
        cyc(2);
        overcurrent = 1'h0;
        chk_val("deepWake", 4'h0, regulatorSuspended);
        finish_wake(n);
        regulator_power_on = 1'h0;
        cyc(2);
        chk_val("pdReg", 4'h0, regulatorEnable);
        regulator_power_on = 1'h1;
        cyc(3);
        chk_val("pdStays", 4'h1, porActive);
        remoteWakeDev = 1'h1;
        cyc(1);
        remoteWakeDev = 1'h0;
        wait_for(0, 1'h0, n);
        chk_win("rmtWake", 2, 20, n);
        extResetN = 1'h0;
        cyc(1);
        extResetN = 1'h1;
        cyc(1);
        chk_val("extRst", 4'h0, regulatorEnable);
        busK = 1'h1;
        cyc(1);
        busK = 1'h0;
        wait_for(0, 1'h0, n);
        chk_win("busWake", 2, 20, n);
        $display("test power done");
    endtask : t_power

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        cyc(19);
        chk_val("rstPor", 4'h1, porActive);
        chk_val("rstLock", 4'h0, writeLock);
        cyc(1);
        rst = 1'h0;
        t_powerup();
        t_idle();
        t_suspend();
        t_select();
        t_remote();
        t_power();
        summarize();
    end

    initial begin
        repeat (6000) @(posedge core_clk);
        n_errors++;
        summarize();
    end
endmodule : usps_power_seq_tb
`default_nettype wire
